/* File: shared/mpps_pkg.sv */
// shared constants, states and carriers of the multiphase phase sequencer
package mpps_pkg;
    // channel count and data widths
    localparam int NCH = 4;
    localparam int DW = 16;
    localparam int STAT_W = 3;
    // register word addresses on the plain register port
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_PERIOD = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h2;
    localparam logic [2:0] ADDR_MASK = 3'h3;
    localparam logic [2:0] ADDR_INFO = 3'h4;
    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_OV_BIT = 0;
    localparam int STAT_UV_BIT = 1;
    localparam int STAT_PG_BIT = 2;
    // values after reset
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [DW-1:0] PERIOD_RST = 16'h001E;
    localparam logic [STAT_W-1:0] MASK_RST = 3'h0;
    // rounding term and divisors for the window and slot arithmetic
    localparam logic [DW:0] WIN_ROUND = 17'h00002;
    localparam logic [DW:0] WIN_DIV = 17'h00003;
    localparam logic [DW-1:0] THIRD_DIV = 16'h0003;
    // phase count codes, taken from {strap4, strap3}
    localparam logic [1:0] CFG_FOUR = 2'h0;
    localparam logic [1:0] CFG_TWO = 2'h1;
    localparam logic [1:0] CFG_THREE = 2'h2;
    localparam logic [1:0] CFG_ONE = 2'h3;
    // active channel masks per count
    localparam logic [NCH-1:0] ACT_FOUR = 4'hF;
    localparam logic [NCH-1:0] ACT_THREE = 4'h7;
    localparam logic [NCH-1:0] ACT_TWO = 4'h3;
    localparam logic [NCH-1:0] ACT_ONE = 4'h1;
    // sequencer states, gray along idle-capture-softstart-run
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CAPT = 2'b01,
        ST_SOFT = 2'b11,
        ST_RUN = 2'b10
    } mpps_state_e;
    // asynchronous pin inputs, synchronised together
    typedef struct packed {
        logic enable;
        logic strap3;
        logic strap4;
        logic softDone;
        logic underV;
        logic overV;
        logic [NCH-1:0] rampCross;
    } mpps_pins_s;
    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } mpps_bus_s;
endpackage

/* File: src/mpps_sequencer.sv */
// phase termination, forced off time, sample-and-hold and supervisory outputs
`timescale 1ns/10ps
module mpps_sequencer
    import mpps_pkg::*;
#(
    parameter int CW = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // asynchronous pins: enable, straps, supervisors, ramp comparators
    input wire mpps_pins_s pinsIn,
    // per-channel sense current from the converter, same clock
    input wire logic [NCH-1:0][CW-1:0] channelSenseCurrent,
    // register port
    input wire mpps_bus_s busIn,
    output logic [DW-1:0] rdData,
    output logic irq,
    // phase outputs to the gate drivers
    output logic [NCH-1:0] phaseOut,
    output logic driverEnableOut,
    // sample-and-hold results
    output logic [NCH-1:0] sampling,
    output logic [NCH-1:0][CW-1:0] sampledCurrent,
    // open-drain power good and the overvoltage latch
    output logic powerGoodFlagOut,
    output logic powerGoodFlagOe,
    output logic overvoltageLatchOut
);

    // reset synchroniser stages
    logic rstMeta;
    logic rstSync;
    // pin synchroniser stages
    mpps_pins_s pinMeta;
    mpps_pins_s pins;
    // sequencer state and captured configuration
    mpps_state_e state;
    mpps_state_e next_state;
    logic [1:0] phaseCfg;
    logic [1:0] next_phaseCfg;
    logic ovLatch;
    logic next_ovLatch;
    logic pgRelease;
    logic next_pgRelease;
    // termination clock counter
    logic [DW-1:0] periodCnt;
    logic [DW-1:0] next_periodCnt;
    // channel state
    logic [NCH-1:0] next_phaseOut;
    logic [NCH-1:0] next_sampling;
    logic [NCH-1:0][DW-1:0] offCnt;
    logic [NCH-1:0][DW-1:0] next_offCnt;
    logic [NCH-1:0][CW-1:0] next_sampledCurrent;
    // registers
    logic ctrlEnable;
    logic next_ctrlEnable;
    logic [DW-1:0] period;
    logic [DW-1:0] next_period;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] next_status;
    logic [STAT_W-1:0] mask;
    logic [STAT_W-1:0] next_mask;
    logic [DW-1:0] next_rdData;
    // derived timing
    logic [DW:0] winSum;
    logic [DW-1:0] winLen;
    logic [DW-1:0] quarter;
    logic [DW-1:0] half;
    logic [DW-1:0] third;
    logic [NCH-1:0][DW-1:0] offs;
    logic [NCH-1:0] active;
    logic enabled;
    logic running;
    logic [STAT_W-1:0] events;

    // reset release through two flip-flops
    // assertion is immediate; release waits two edges so all flops leave reset together
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // two-stage synchroniser for every pin input
    // straps ride along with the other pins; they are read only in capture, so skew is harmless
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            pinMeta <= '0;
            pins <= '0;
        end else begin
            pinMeta <= pinsIn;
            pins <= pinMeta;
        end
    end

    // window length rounds the third up, slot offsets per phase count
    // rounding up keeps the sample on short periods; quarter slots use the floor,
    // so the last slot of four may run a little long
    always_comb begin
        winSum = {1'b0, period} + WIN_ROUND;
        winLen = DW'(winSum / WIN_DIV);
        quarter = period >> 2;
        half = period >> 1;
        third = period / THIRD_DIV;
        offs = '0;
        active = ACT_FOUR;
        unique case (phaseCfg)
            CFG_FOUR: begin
                active = ACT_FOUR;
                offs[1] = quarter;
                offs[2] = quarter + quarter;
                offs[3] = quarter + quarter + quarter;
            end
            CFG_TWO: begin
                active = ACT_TWO;
                offs[1] = half;
            end
            CFG_THREE: begin
                active = ACT_THREE;
                offs[1] = third;
                offs[2] = third + third;
            end
            CFG_ONE: begin
                active = ACT_ONE;
            end
        endcase
    end

    // sequencer control: enable, strap capture, soft-start, faults
    // overvoltage stops switching at once but keeps the state; only a disable
    // sends the sequence back through capture and soft-start
    always_comb begin
        enabled = pins.enable && ctrlEnable;
        next_state = state;
        next_phaseCfg = phaseCfg;
        next_ovLatch = ovLatch;
        if (!enabled) begin
            // disable clears the latch and rearms soft-start
            next_state = ST_IDLE;
            next_ovLatch = 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: next_state = ST_CAPT;
                ST_CAPT: begin
                    // straps are frozen here, before any switching
                    next_phaseCfg = {pins.strap4, pins.strap3};
                    next_state = ST_SOFT;
                end
                ST_SOFT: begin
                    if (pins.softDone) begin
                        next_state = ST_RUN;
                    end
                end
                ST_RUN: next_state = ST_RUN;
            endcase
            if (pins.overV && state != ST_IDLE) begin
                next_ovLatch = 1'b1;
            end
        end
        running = (state == ST_SOFT || state == ST_RUN) && !ovLatch;
        // released only in run, pulled low on undervoltage
        next_pgRelease = enabled && state == ST_RUN && !pins.underV;
        next_periodCnt = '0;
        if (running) begin
            // termination clock: one tick per switching period
            // a period written below the count wraps at once instead of running on
            next_periodCnt = (periodCnt >= period - 16'h0001) ? '0 : periodCnt + 16'h0001;
        end
    end

    // control registers
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            state <= ST_IDLE;
            phaseCfg <= CFG_FOUR;
            ovLatch <= 1'b0;
            pgRelease <= 1'b0;
            periodCnt <= '0;
        end else begin
            state <= next_state;
            phaseCfg <= next_phaseCfg;
            ovLatch <= next_ovLatch;
            pgRelease <= next_pgRelease;
            periodCnt <= next_periodCnt;
        end
    end

    // per-channel termination, forced off, sample window and hold
    // a phase falls only on its termination tick or on a stop; the forced off time
    // reuses the window counter, so the earliest rise is one cycle after the window
    always_comb begin
        next_phaseOut = phaseOut;
        next_sampling = sampling;
        next_offCnt = offCnt;
        next_sampledCurrent = sampledCurrent;
        for (int k = 0; k < NCH; k++) begin
            if (!running || !active[k]) begin
                // idle channel: low, not sampling
                next_phaseOut[k] = 1'b0;
                next_sampling[k] = 1'b0;
                next_offCnt[k] = '0;
            end else if (periodCnt == offs[k]) begin
                // termination tick: drop the phase and open the window
                next_phaseOut[k] = 1'b0;
                next_sampling[k] = 1'b1;
                next_offCnt[k] = winLen - 16'h0001;
            end else if (offCnt[k] != '0) begin
                // forced off time counting down
                next_offCnt[k] = offCnt[k] - 16'h0001;
            end else if (sampling[k]) begin
                // window closes: hold the value until the next window ends
                next_sampling[k] = 1'b0;
                next_sampledCurrent[k] = channelSenseCurrent[k];
            end else if (pins.rampCross[k]) begin
                // set high, stays high until the next termination
                next_phaseOut[k] = 1'b1;
            end
        end
    end

    // channel registers
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            phaseOut <= '0;
            sampling <= '0;
            offCnt <= '0;
            sampledCurrent <= '0;
        end else begin
            phaseOut <= next_phaseOut;
            sampling <= next_sampling;
            offCnt <= next_offCnt;
            sampledCurrent <= next_sampledCurrent;
        end
    end

    // register writes, sticky status, read data one cycle later
    // unmapped writes leave every register alone and unmapped reads return zero
    // events are edges of registered supervisory state, so each one fires once
    always_comb begin
        next_ctrlEnable = ctrlEnable;
        next_period = period;
        next_mask = mask;
        next_status = status;
        next_rdData = '0;
        // events: overvoltage latch, power good drop, power good release
        events = '0;
        events[STAT_OV_BIT] = next_ovLatch && !ovLatch;
        events[STAT_UV_BIT] = pgRelease && !next_pgRelease && pins.underV;
        events[STAT_PG_BIT] = next_pgRelease && !pgRelease;
        if (busIn.wr) begin
            unique case (busIn.addr)
                ADDR_CTRL: next_ctrlEnable = busIn.wdata[CTRL_EN_BIT];
                ADDR_PERIOD: next_period = busIn.wdata;
                ADDR_STATUS: next_status = status & ~busIn.wdata[STAT_W-1:0];
                ADDR_MASK: next_mask = busIn.wdata[STAT_W-1:0];
                default: next_status = status;
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_status = next_status | events;
        if (busIn.rd) begin
            unique case (busIn.addr)
                ADDR_CTRL: next_rdData = {15'h0000, ctrlEnable};
                ADDR_PERIOD: next_rdData = period;
                ADDR_STATUS: next_rdData = {13'h0000, status};
                ADDR_MASK: next_rdData = {13'h0000, mask};
                // info: phases, ov latch, pg released, config, state
                ADDR_INFO: next_rdData = {6'h00, phaseOut, ovLatch, pgRelease, phaseCfg, state};
                default: next_rdData = '0;
            endcase
        end
    end

    // register file storage
    // read data fall back to zero the cycle after a read
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            ctrlEnable <= CTRL_EN_RST;
            period <= PERIOD_RST;
            status <= '0;
            mask <= MASK_RST;
            rdData <= '0;
        end else begin
            ctrlEnable <= next_ctrlEnable;
            period <= next_period;
            status <= next_status;
            mask <= next_mask;
            rdData <= next_rdData;
        end
    end

    // outputs built from registers
    // power good is open drain: its data stay low and the enable does the work
    assign irq = |(status & mask);
    assign driverEnableOut = (state != ST_IDLE) && !ovLatch;
    assign powerGoodFlagOut = 1'b0;
    assign powerGoodFlagOe = !pgRelease;
    assign overvoltageLatchOut = ovLatch;

    // checks
    // checks watch registered state and the channelSenseCurrent input only and sleep while the local reset is low
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstSync);

    tickPhase1_a: assert property (running && $past(running) && periodCnt == '0 |=> !phaseOut[0])
        else $error("phase 1 not low after termination tick");
    idleLow_a: assert property (state == ST_IDLE |=> phaseOut == '0 && !pgRelease)
        else $error("outputs active while disabled");
    pgSoft_a: assert property (pgRelease |-> $past(state) == ST_RUN)
        else $error("power good released before soft-start end");
    pgUnder_a: assert property (pins.underV |=> !pgRelease)
        else $error("power good released under undervoltage");
    ovSet_a: assert property (pins.overV && enabled && state != ST_IDLE |=> ovLatch)
        else $error("overvoltage not latched");
    ovHold_a: assert property (ovLatch && enabled |=> ovLatch)
        else $error("overvoltage latch dropped while enabled");
    ovClear_a: assert property (!enabled |=> !ovLatch && state == ST_IDLE)
        else $error("disable did not clear fault");
    cfgFixed_a: assert property (state != ST_CAPT && $past(state) != ST_CAPT |-> $stable(phaseCfg))
        else $error("phase count changed outside capture");
    // status bits must follow the supervisory events they stand for
    stickyOv_a: assert property ($rose(ovLatch) |-> status[STAT_OV_BIT])
        else $error("overvoltage event not recorded");
    pgDrop_a: assert property ($fell(pgRelease) && $past(pins.underV)
        |-> status[STAT_UV_BIT])
        else $error("undervoltage drop not recorded");

    genvar g;
    for (g = 0; g < NCH; g++) begin : g_chk
        offTime_a: assert property ($rose(phaseOut[g]) |-> $past(offCnt[g]) == '0 && !$past(sampling[g]))
            else $error("phase rose inside forced off time");
        sampleStart_a: assert property ($fell(phaseOut[g]) && $past(running)
            |-> sampling[g])
            else $error("sampling not started on falling edge");
        windowLen_a: assert property ($rose(sampling[g]) |-> offCnt[g] == winLen - 16'h0001)
            else $error("sample window length wrong");
        unused_a: assert property (!active[g] |=> !phaseOut[g] && !sampling[g])
            else $error("unused channel active");
        holdVal_a: assert property (!$fell(sampling[g]) |-> $stable(sampledCurrent[g]))
            else $error("held sample changed outside window end");
        winClose_a: assert property ($fell(sampling[g]) && $past(running)
            |-> $past(offCnt[g]) == '0)
            else $error("sample window closed early");
        holdTake_a: assert property ($fell(sampling[g]) && $past(running)
            |-> sampledCurrent[g] == $past(channelSenseCurrent[g]))
            else $error("held sample not taken at window end");
    end

endmodule // mpps_sequencer

/* File: tb/mpps_driver_model.sv */
// gate driver stand-in: returns a sense current that steps with each phase pulse
`timescale 1ns/10ps
module mpps_driver_model
    import mpps_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // gate commands from the sequencer
    input wire logic [NCH-1:0] phaseOut,
    input wire logic driverEnableOut,
    // sensed current back to the sequencer
    output logic [NCH-1:0][7:0] senseOut
);
    logic [NCH-1:0] phaseQ; // last cycle's gate command
    // current steps one cycle after a rising command, so it stands still in the window
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phaseQ <= '0;
            senseOut <= '0;
        end else begin
            phaseQ <= phaseOut;
            for (int k = 0; k < NCH; k++) begin
                // drivers off: no current flows
                if (!driverEnableOut) begin
                    senseOut[k] <= 8'h00;
                end else if (phaseOut[k] && !phaseQ[k]) begin
                    senseOut[k] <= senseOut[k] + 8'h11 + 8'(k);
                end
            end
        end
    end
endmodule // mpps_driver_model

/* File: tb/test_mpps_sequencer.sv */
// self-checking bench for the multiphase phase sequencer
`timescale 1ns/10ps
module test_mpps_sequencer;
    import mpps_pkg::*;
    localparam int PI = 12; // switching period in clocks
    localparam int W = 4; // sample window, a third of PI rounded up
    logic clk_sys = 1'b0; // system clock
    logic nrst = 1'b0; // reset, active low
    mpps_pins_s pins = '0; // pin levels
    mpps_bus_s bus = '0; // register port request
    logic [NCH-1:0][7:0] sense; // from the driver model
    logic [NCH-1:0][7:0] held; // sample-and-hold results
    logic [NCH-1:0] phase, samp; // phase outputs and windows
    logic [DW-1:0] rdData, d; // read data and its copy
    logic irq, driver_enable_out, pgOut, pgOe, ovl, ph0; // single outputs
    int n_fail = 0;
    int compares = 0;
    assign ph0 = phase[0];
    always #50 clk_sys = ~clk_sys;
    mpps_sequencer #(.CW(8)) i_mpps_sequencer (.clk_sys(clk_sys), .nrst(nrst), .pinsIn(pins),
        .channelSenseCurrent(sense), .busIn(bus), .rdData(rdData), .irq(irq), .phaseOut(phase),
        .driverEnableOut(driver_enable_out), .sampling(samp), .sampledCurrent(held),
        .powerGoodFlagOut(pgOut), .powerGoodFlagOe(pgOe), .overvoltageLatchOut(ovl));
    mpps_driver_model i_mpps_driver_model (.clk_sys(clk_sys), .nrst(nrst), .phaseOut(phase),
        .driverEnableOut(driver_enable_out), .senseOut(sense));
    // step past edges; inputs then change just after the edge
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // bounded wait for a level; running out ends the run
    task automatic waitfor(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++) tick(1);
        if (s !== v) begin
            n_fail++;
            $display("BAD %0t wait ran out", $time);
            test_done();
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [DW-1:0] v);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        tick(1);
        bus <= '0;
        tick(1);
    endtask
    // read data stand in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [DW-1:0] v);
        bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        tick(1);
        bus <= '0;
        v = rdData;
        tick(1);
    endtask
    task automatic t_reset;
        check(phase === 4'h0 && samp === 4'h0 && ovl === 1'b0, "reset outputs");
        check(driver_enable_out === 1'b0 && pgOe === 1'b1 && irq === 1'b0, "reset flags");
    endtask
    // register defaults, period write, unmapped address
    task automatic t_regs;
        rd(ADDR_CTRL, d);
        check(d[CTRL_EN_BIT] === CTRL_EN_RST, "ctrl reset");
        wr(ADDR_CTRL, 16'h0000);
        rd(ADDR_CTRL, d);
        check(d === 16'h0000, "ctrl write");
        wr(ADDR_CTRL, 16'h0001);
        rd(ADDR_PERIOD, d);
        check(d === PERIOD_RST, "period reset");
        wr(ADDR_PERIOD, 16'(PI));
        rd(ADDR_PERIOD, d);
        check(d === 16'(PI), "period write");
        wr(3'h5, 16'hFFFF);
        rd(3'h5, d);
        check(d === 16'h0000, "unmapped read");
    endtask
    // straps pick count and spacing; a strap flip mid-run must change nothing
    task automatic t_phases(input logic [1:0] cfg);
        int n;
        int rise[NCH] = '{default: -1};
        int hits[NCH] = '{default: 0};
        logic [NCH-1:0] ps = '0;
        logic [NCH-1:0] pp = '0;
        n = (cfg == CFG_FOUR) ? 4 : (cfg == CFG_TWO) ? 2 : (cfg == CFG_THREE) ? 3 : 1;
        pins.enable <= 1'b0;
        tick(6);
        pins.strap3 <= cfg[0];
        pins.strap4 <= cfg[1];
        pins.enable <= 1'b1;
        for (int c = 0; c < 5 * PI; c++) begin
            tick(1);
            if (c == 3 * PI) pins.strap3 <= ~cfg[0];
            for (int k = 0; k < NCH; k++) begin
                if (pp[k] && !phase[k]) check(samp[k] && !ps[k], "fall without window");
                if (!ps[k] && samp[k]) begin
                    if (k == 0 && rise[0] >= 0) check(c - rise[0] == PI, "period");
                    rise[k] = c;
                    hits[k]++;
                end
                if (ps[k] && !samp[k]) begin
                    check(c - rise[k] == W, "window length");
                    check(held[k] === sense[k], "held sample");
                end
                if (!pp[k] && phase[k]) check(c - rise[k] > W, "off time");
            end
            pp = phase;
            ps = samp;
        end
        for (int k = 0; k < NCH; k++) begin
            if (k < n) check((rise[k] - rise[0] + PI) % PI == k * (PI / n), "spacing");
            else check(hits[k] == 0 && phase[k] === 1'b0, "idle channel");
        end
        pins.strap3 <= 1'b0;
        pins.strap4 <= 1'b0;
    endtask
    // the ramp sets a phase after its off time, only termination clears it
    task automatic t_ramp;
        pins.rampCross <= 4'h0;
        for (int c = 0; c < 2 * PI; c++) begin
            tick(1);
            if (c > PI + 3) check(phase === 4'h0, "set without ramp");
        end
        pins.rampCross <= 4'hF;
        waitfor(ph0, 1'b1, 2 * PI);
        pins.rampCross <= 4'h0;
        for (int c = 0; c < PI + 2 && samp[0] !== 1'b1; c++) begin
            check(ph0 === 1'b1, "early clear");
            tick(1);
        end
        pins.rampCross <= 4'hF;
    endtask
    // power good waits for soft-start, drops on undervoltage, raises a maskable irq
    task automatic t_pg;
        pins.enable <= 1'b0;
        pins.softDone <= 1'b0;
        tick(6);
        pins.enable <= 1'b1;
        tick(3 * PI);
        check(pgOe === 1'b1 && pgOut === 1'b0, "released early");
        rd(ADDR_INFO, d);
        check(d[1:0] === ST_SOFT, "not in soft-start");
        pins.softDone <= 1'b1;
        waitfor(pgOe, 1'b0, 8);
        rd(ADDR_STATUS, d);
        check(d[STAT_PG_BIT] === 1'b1, "pg release status");
        wr(ADDR_MASK, 16'h0002);
        wr(ADDR_STATUS, 16'h0007);
        tick(2);
        check(irq === 1'b0, "irq before event");
        pins.underV <= 1'b1;
        waitfor(pgOe, 1'b1, 8);
        tick(2);
        check(irq === 1'b1, "irq missing");
        wr(ADDR_MASK, 16'h0000);
        tick(2);
        check(irq === 1'b0, "mask ignored");
        pins.underV <= 1'b0;
        waitfor(pgOe, 1'b0, 8);
        wr(ADDR_MASK, 16'h0002);
        wr(ADDR_STATUS, 16'h0002);
        tick(2);
        check(irq === 1'b0, "clear ignored");
    endtask
    // overvoltage latches and stops the drivers; only a disable clears it
    task automatic t_ov;
        pins.overV <= 1'b1;
        waitfor(ovl, 1'b1, 8);
        pins.overV <= 1'b0;
        tick(2 * PI);
        check(ovl === 1'b1 && driver_enable_out === 1'b0, "latch lost");
        rd(ADDR_STATUS, d);
        check(d[STAT_OV_BIT] === 1'b1, "ov status");
        pins.enable <= 1'b0;
        waitfor(ovl, 1'b0, 8);
        tick(2);
        check(phase === 4'h0 && driver_enable_out === 1'b0 && pgOe === 1'b1, "disabled outputs");
        pins.enable <= 1'b1;
        waitfor(ph0, 1'b1, 3 * PI);
    endtask
    // main sequence: reset held three cycles, then the scenarios
    initial begin
        tick(3);
        t_reset();
        nrst <= 1'b1;
        tick(3);
        t_regs();
        pins.rampCross <= 4'hF;
        pins.softDone <= 1'b1;
        for (int c = 0; c < 4; c++) t_phases(c[1:0]);
        t_ramp();
        t_pg();
        t_ov();
        test_done();
    end
endmodule // test_mpps_sequencer
